// ===== bench/io_pin_multiplexer_tb.sv
// Purpose: bench, smallest package
// Assumes: inputs change at the falling edge
// Notes: pads resolve device, model and pull-up
`timescale 1ns/10ps
`default_nettype none
module io_pin_multiplexer_tb;
   import pmux_pkg::*;
   localparam int PC = PMUX_PINS_SMALL;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic mux_en_i = 1'b1;
   logic cfg_load_i = 1'b0;
   logic [PC-1:0][PMUX_SEL_W-1:0] cfg_sel_i = '0;
   logic [PC-1:0][1:0] cfg_mode_i = '0;
   logic [PC-1:0] pin_out, pin_oe, pad, m_drv, m_en;
   logic [PMUX_NSIG-1:0] per_out_i = '0, per_oe_i = '0, per_in;
   logic tx_ready = 1'b0, rx_valid = 1'b0, push, pop, err;
   logic [7:0] rx_byte = 8'h00, tx_byte;
   logic [1:0] state;
   int err_count = 0, total_checks = 0, pushes = 0, pops = 0, cyc = 0;
   always #5 clk_i = ~clk_i;
   assign pad = (pin_oe & pin_out) | (~pin_oe & ~m_en) | (~pin_oe & m_en & m_drv);
   pmux_top #(.PIN_COUNT(PC)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .mux_en_i(mux_en_i),
      .cfg_load_i(cfg_load_i), .cfg_sel_i(cfg_sel_i), .cfg_mode_i(cfg_mode_i), .sync_fifo_i(1'b0),
      .configurable_pin_in_i(pad), .configurable_pin_out_o(pin_out), .configurable_pin_oe_o(pin_oe),
      .per_out_i(per_out_i), .per_oe_i(per_oe_i), .per_in_o(per_in), .fifo_tx_ready_i(tx_ready),
      .fifo_tx_push_o(push), .fifo_tx_byte_o(tx_byte), .fifo_rx_valid_i(rx_valid),
      .fifo_rx_byte_i(rx_byte), .fifo_rx_pop_o(pop), .cfg_err_o(err), .mux_state_o(state));
   pmux_pin_model pm (.clk_i(clk_i), .pad_i(pad), .drv_o(m_drv), .en_o(m_en));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic load(input logic [PC-1:0][PMUX_SEL_W-1:0] s, input logic [PC-1:0][1:0] m);
      cfg_sel_i = s;
      cfg_mode_i = m;
      cfg_load_i = 1'b1;
      @(negedge clk_i);
      cfg_load_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : load
   always @(posedge clk_i) begin
      cyc++;
      pushes += int'(push === 1'b1);
      pops += int'(pop === 1'b1);
      if (cyc == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      logic [PC-1:0][PMUX_SEL_W-1:0] s, t;
      logic [PC-1:0][1:0] m, tm;
      logic [11:0] v;
      logic [7:0] b, got;
      pmux_sel_t id;
      int bp[3] = '{8, 9, 11};
      pmux_sel_t bi[3] = '{SIG_FIFO_RXF_N, SIG_FIFO_RXF_N, SIG_SERIAL_RING_N};
      logic [1:0] bm[3] = '{2'h3, 2'h1, 2'h1};
      void'($urandom(69884));
      repeat (5) @(negedge clk_i);
      resetn_i = 1'b1;
      per_out_i = PMUX_NSIG'({$urandom(), $urandom(), $urandom()});
      per_oe_i = PMUX_NSIG'({$urandom(), $urandom(), $urandom()});
      v = 12'($urandom());
      pm.drive(v, 12'hFFF);
      repeat (6) @(negedge clk_i);
      chk(8'(state), 8'h01, "default state");
      for (int p = 0; p < PC; p++) begin
         id = (p == 0) ? SIG_DEBUG : SIG_GPIO + 7'(p);
         chk(8'(pin_oe[p]), 8'(per_oe_i[id]), "default oe");
         if (per_oe_i[id]) chk(8'(pin_out[p]), 8'(per_out_i[id]), "pin out");
         else chk(8'(per_in[id]), 8'(v[p]), "pin in");
      end
      for (int i = 0; i < 8; i++) begin
         s[i] = SIG_FIFO_DATA + 7'(i);
         m[i] = 2'h2;
      end
      s[11:8] = {SIG_FIFO_WR_N, SIG_FIFO_RD_N, SIG_FIFO_TXE_N, SIG_FIFO_RXF_N};
      m[11:8] = {2'h0, 2'h0, 2'h1, 2'h1};
      pm.drive(12'hC00, 12'hC00);
      load(s, m);
      chk(8'(err), 8'h00, "good load");
      chk(8'(state), 8'h02, "user state");
      for (int k = 0; k < 4; k++) begin
         {tx_ready, rx_valid} = 2'(k);
         repeat (3) @(negedge clk_i);
         chk(8'(pad[9]), 8'(!tx_ready), "space flag");
         chk(8'(pad[8]), 8'(!rx_valid), "data flag");
      end
      rx_byte = 8'($urandom());
      b = 8'($urandom());
      pm.write_byte(b);
      repeat (4) @(negedge clk_i);
      chk(tx_byte, b, "captured byte");
      chk(8'(pushes), 8'h01, "one push");
      pm.read_byte(got);
      chk(got, rx_byte, "read byte");
      repeat (4) @(negedge clk_i);
      chk(8'(pops), 8'h01, "one pop");
      foreach (bp[k]) begin
         t = s;
         tm = m;
         t[bp[k]] = bi[k];
         tm[bp[k]] = bm[k];
         load(t, tm);
         chk(8'(err), 8'h01, "refused entry");
         chk(8'(pin_oe[bp[k]]), 8'h00, "refused pin");
      end
      mux_en_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk(8'(|pin_oe), 8'h00, "off pads");
      mux_en_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk(8'(state), 8'h01, "re-enable");
      end_of_test();
   end
endmodule : io_pin_multiplexer_tb
bind pmux_top pmux_top_props #(.PIN_COUNT(PIN_COUNT)) u_props (.clk_i(clk_i), .resetn_i(resetn_i),
   .mux_en_i(mux_en_i), .cfg_load_i(cfg_load_i), .cfg_sel_i(cfg_sel_i), .cfg_mode_i(cfg_mode_i),
   .configurable_pin_oe_o(configurable_pin_oe_o), .fifo_tx_push_o(fifo_tx_push_o),
   .fifo_rx_pop_o(fifo_rx_pop_o), .cfg_err_o(cfg_err_o), .mux_state_o(mux_state_o));
`default_nettype wire

// ===== bench/pmux_pin_model.sv
// Purpose: external port writer and reader
// Assumes: data on pins 0-7, flags 8-9, strobes 10-11
// Notes: released lines float to the pull-up
`timescale 1ns/10ps
`default_nettype none
module pmux_pin_model (
   input wire logic clk_i,
   input wire logic [11:0] pad_i,
   output logic [11:0] drv_o,
   output logic [11:0] en_o
);
   // drive v on the pins that e enables, the rest are released
   task automatic drive(input logic [11:0] v, input logic [11:0] e);
      drv_o = v;
      en_o = e;
   endtask : drive
   initial drive(12'h000, 12'h000);
   // bounded wait, a stuck flag shows up as a data miscompare
   task automatic wait_low(input int p);
      for (int n = 0; n < 50 && pad_i[p] !== 1'b0; n++) @(negedge clk_i);
   endtask : wait_low
   task automatic write_byte(input logic [7:0] b);
      wait_low(9);
      drv_o = {4'hC, b};
      en_o = 12'hCFF;
      repeat (3) @(negedge clk_i);
      drv_o[11] = 1'b0;
      repeat (8) @(negedge clk_i);
      drv_o[11] = 1'b1;
      repeat (2) @(negedge clk_i);
      en_o = 12'hC00;
   endtask : write_byte
   task automatic read_byte(output logic [7:0] b);
      wait_low(8);
      drv_o[10] = 1'b0;
      repeat (8) @(negedge clk_i);
      b = pad_i[7:0];
      drv_o[10] = 1'b1;
   endtask : read_byte
endmodule : pmux_pin_model
`default_nettype wire

// ===== bench/pmux_top_props.sv
// Purpose: port checks
// Assumes: one clock, reset active low
// Notes: bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module pmux_top_props
   import pmux_pkg::*;
#(
   parameter int PIN_COUNT = 12
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic mux_en_i,
   input wire logic cfg_load_i,
   input wire logic [PIN_COUNT-1:0][PMUX_SEL_W-1:0] cfg_sel_i,
   input wire logic [PIN_COUNT-1:0][1:0] cfg_mode_i,
   input wire logic [PIN_COUNT-1:0] configurable_pin_oe_o,
   input wire logic fifo_tx_push_o,
   input wire logic fifo_rx_pop_o,
   input wire logic cfg_err_o,
   input wire logic [1:0] mux_state_o
);
   // ==========================================================================
   // checks
   // ==========================================================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire load_w = mux_en_i && cfg_load_i; // a load is taken
   a_off_all_input: assert property (!mux_en_i [*3] |-> configurable_pin_oe_o == '0)
      else $error("pads driven while off");
   a_load_user: assert property (load_w |=> mux_state_o == 2'h2)
      else $error("load missed user state");
   a_enable_default: assert property (mux_state_o == 2'h0 && !load_w && mux_en_i
      |=> mux_state_o == 2'h1)
      else $error("no defaults on enable");
   a_bad_mode: assert property (load_w && cfg_mode_i[8] == 2'h3
      |=> cfg_err_o ##1 !configurable_pin_oe_o[8])
      else $error("illegal mode accepted");
   a_group_err: assert property (load_w && cfg_sel_i[9] == SIG_FIFO_RXF_N
      |=> cfg_err_o ##1 !configurable_pin_oe_o[9])
      else $error("wrong group accepted");
   a_err_cause: assert property ($rose(cfg_err_o) |-> $past(load_w))
      else $error("error without load");
   a_push_pulse: assert property (fifo_tx_push_o |=> !fifo_tx_push_o)
      else $error("push too long");
   a_pop_pulse: assert property (fifo_rx_pop_o |=> !fifo_rx_pop_o)
      else $error("pop too long");
   c_load: cover property (load_w);
   c_push: cover property (fifo_tx_push_o);
   c_pop: cover property (fifo_rx_pop_o);
endmodule : pmux_top_props
`default_nettype wire

// ===== design/pmux_fifo_if.sv
// Purpose: parallel port strobes, flags and data between mux and port
// Assumes: every member is on clk_i and already synchronised
// Notes: strobe and flag members are active low levels
`timescale 1ns/10ps
`default_nettype none
interface pmux_fifo_if;
   logic wr_n; // routed write strobe
   logic rd_n; // routed read strobe
   logic oe_n; // routed output enable
   logic sync_mode; // synchronous port mode
   logic [7:0] bus_in; // byte seen on the data pins
   logic [7:0] bus_out; // byte to drive on the data pins
   logic bus_oe; // data pins driven
   logic txe_n; // transmit space flag
   logic rxf_n; // receive available flag
   modport mux (output wr_n, rd_n, oe_n, sync_mode, bus_in, input bus_out, bus_oe, txe_n, rxf_n);
   modport port (input wr_n, rd_n, oe_n, sync_mode, bus_in, output bus_out, bus_oe, txe_n, rxf_n);
endinterface : pmux_fifo_if
`default_nettype wire

// ===== design/pmux_fifo_port.sv
// Purpose: strobe handshake of the byte-wide parallel port
// Assumes: strobes arrive synchronised; buffers sit in user logic
// Notes: all outputs are registered; edges are detected on the synchronised levels
`timescale 1ns/10ps
`default_nettype none
module pmux_fifo_port
   import pmux_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   pmux_fifo_if.port fif,
   input wire logic tx_ready_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   output logic tx_push_o,
   output logic [7:0] tx_byte_o,
   output logic rx_pop_o
);

   // ==========================================================================
   // edge detection
   // ==========================================================================
   logic wr_prev_q; // last write strobe level
   logic rd_prev_q; // last read strobe level
   logic push_q; // byte taken pulse
   logic pop_q; // byte consumed pulse
   logic [7:0] byte_q; // captured byte
   logic [7:0] out_q; // byte driven outward
   logic oe_q; // bus drive
   logic txe_q; // space flag
   logic rxf_q; // data flag
   wire logic wr_fall = wr_prev_q & ~fif.wr_n; // write strobe high to low
   wire logic rd_fall = rd_prev_q & ~fif.rd_n; // read strobe high to low
   // synchronous mode drives on the output enable, asynchronous on the read strobe
   wire logic drive_d = fif.sync_mode ? ~fif.oe_n : ~fif.rd_n;

   // strobe history and pulses; a write with no room is dropped, not queued
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_prev_q <= 1'b0; // routed strobes reset low, so no false edge
         rd_prev_q <= 1'b0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         byte_q <= 8'h00;
      end else begin
         wr_prev_q <= fif.wr_n;
         rd_prev_q <= fif.rd_n;
         push_q <= wr_fall & tx_ready_i;
         pop_q <= rd_fall & rx_valid_i;
         if (wr_fall) begin
            byte_q <= fif.bus_in;
         end
      end
   end

   // flags and outgoing byte
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_q <= 8'h00;
         oe_q <= 1'b0;
         txe_q <= 1'b1;
         rxf_q <= 1'b1;
      end else begin
         out_q <= rx_byte_i;
         oe_q <= drive_d;
         txe_q <= ~tx_ready_i;
         rxf_q <= ~rx_valid_i;
      end
   end

   assign fif.bus_out = out_q;
   assign fif.bus_oe = oe_q;
   assign fif.txe_n = txe_q;
   assign fif.rxf_n = rxf_q;
   assign tx_push_o = push_q;
   assign tx_byte_o = byte_q;
   assign rx_pop_o = pop_q;

endmodule : pmux_fifo_port
`default_nettype wire

// ===== design/pmux_pkg.sv
// Purpose: constants, signal identifiers and decoders
// Assumes: one seven-bit identifier per routed signal
// Notes: identifier zero means the pin carries no peripheral signal
package pmux_pkg;

   // ==========================================================================
   // package options
   // ==========================================================================
   localparam int PMUX_PINS_SMALL = 12; // smallest package option
   localparam int PMUX_PINS_MID = 28; // middle package option
   localparam int PMUX_PINS_LARGE = 44; // largest package option
   localparam int PMUX_GROUPS = 4; // pins per group stride

   // ==========================================================================
   // signal identifiers
   // ==========================================================================
   localparam int PMUX_SEL_W = 7; // width of a signal identifier
   localparam int PMUX_NSIG = 86; // identifiers 0 .. 85
   typedef logic [PMUX_SEL_W-1:0] pmux_sel_t;

   localparam pmux_sel_t SIG_NONE = 7'h00; // unassigned pin
   localparam pmux_sel_t SIG_DEBUG = 7'h01; // debugger line, both ways
   localparam pmux_sel_t SIG_SER_TXD = 7'h02; // serial transmit data
   localparam pmux_sel_t SIG_SER_DTR_N = 7'h03; // terminal ready, active low
   localparam pmux_sel_t SIG_SER_TX_ACTIVE = 7'h04; // line driver enable
   localparam pmux_sel_t SIG_SER_RTS_N = 7'h05; // request to send, active low
   localparam pmux_sel_t SIG_SER_RXD = 7'h06; // serial receive data
   localparam pmux_sel_t SIG_SER_DSR_N = 7'h07; // set ready, active low
   localparam pmux_sel_t SIG_SER_DCD_N = 7'h08; // carrier detect, active low
   localparam pmux_sel_t SIG_SER_CTS_N = 7'h09; // clear to send, active low
   localparam pmux_sel_t SIG_SERIAL_RING_N = 7'h0A; // ring indicate, active low
   localparam pmux_sel_t SIG_FIFO_DATA = 7'h0B; // data bits 0..7 at 0x0B..0x12
   localparam pmux_sel_t SIG_FIFO_RXF_N = 7'h13; // receive available flag
   localparam pmux_sel_t SIG_FIFO_TXE_N = 7'h14; // transmit space flag
   localparam pmux_sel_t SIG_FIFO_RD_N = 7'h15; // read strobe
   localparam pmux_sel_t SIG_FIFO_WR_N = 7'h16; // write strobe
   localparam pmux_sel_t SIG_FIFO_OE_N = 7'h17; // output enable, synchronous mode
   localparam pmux_sel_t SIG_FIFO_CLKOUT = 7'h18; // clock out, synchronous mode
   localparam pmux_sel_t SIG_SLAVE0_CLK = 7'h19; // slave 0 clock in
   localparam pmux_sel_t SIG_SLAVE1_CLK = 7'h1A; // slave 1 clock in
   localparam pmux_sel_t SIG_SLAVE0_MOSI = 7'h1B; // slave 0 data in
   localparam pmux_sel_t SIG_SLAVE1_MOSI = 7'h1C; // slave 1 data in
   localparam pmux_sel_t SIG_SLAVE0_OUT = 7'h1D; // slave 0 data out
   localparam pmux_sel_t SIG_SLAVE1_OUT = 7'h1E; // slave 1 data out
   localparam pmux_sel_t SIG_SLAVE0_SEL_N = 7'h1F; // slave 0 select in
   localparam pmux_sel_t SIG_SLAVE1_SEL_N = 7'h20; // slave 1 select in
   localparam pmux_sel_t SIG_MST_CLK = 7'h21; // master clock out
   localparam pmux_sel_t SIG_MST_MOSI = 7'h22; // master data out
   localparam pmux_sel_t SIG_MST_MISO = 7'h23; // master data in
   localparam pmux_sel_t SIG_MST_SEL0_N = 7'h24; // master select 0 out
   localparam pmux_sel_t SIG_MST_SEL1_N = 7'h25; // master select 1 out
   localparam pmux_sel_t SIG_PWM = 7'h26; // pwm 0..7 at 0x26..0x2D
   localparam pmux_sel_t SIG_GPIO = 7'h2E; // gpio 0..39 at 0x2E..0x55
   localparam pmux_sel_t SIG_LAST = 7'h55; // highest legal identifier

   // ==========================================================================
   // pad modes and controller states
   // ==========================================================================
   typedef enum logic [1:0] {PAD_IN, PAD_OUT, PAD_BIDIR} pmux_mode_e;
   typedef enum logic [1:0] {MUX_OFF, MUX_DEFAULT, MUX_USER} pmux_state_e;

   // group of a signal; banked signals take the group from their bit number
   function automatic logic [1:0] pmux_group(input pmux_sel_t id);
      pmux_sel_t off;
      off = SIG_NONE;
      case (id) inside
         [SIG_FIFO_DATA:SIG_FIFO_DATA+7'h07]: off = id - SIG_FIFO_DATA;
         [SIG_PWM:SIG_PWM+7'h07]: off = id - SIG_PWM;
         [SIG_GPIO:SIG_LAST]: off = id - SIG_GPIO;
         SIG_DEBUG, SIG_SER_TXD, SIG_SER_DTR_N, SIG_SER_TX_ACTIVE, SIG_FIFO_RXF_N,
            SIG_FIFO_OE_N, SIG_SLAVE0_CLK, SIG_SLAVE1_CLK, SIG_MST_CLK,
            SIG_MST_SEL1_N: off = 7'h00;
         SIG_SER_RXD, SIG_SER_DSR_N, SIG_FIFO_TXE_N, SIG_FIFO_CLKOUT, SIG_SLAVE0_MOSI,
            SIG_SLAVE1_MOSI, SIG_MST_MOSI: off = 7'h01;
         SIG_SER_RTS_N, SIG_SER_DCD_N, SIG_FIFO_RD_N, SIG_SLAVE0_OUT, SIG_SLAVE1_OUT,
            SIG_MST_MISO: off = 7'h02;
         default: off = 7'h03;
      endcase
      return off[1:0];
   endfunction : pmux_group

   // signal may be driven onto a pin
   function automatic logic pmux_can_out(input pmux_sel_t id);
      return (id inside {SIG_DEBUG, [SIG_SER_TXD:SIG_SER_RTS_N],
                         [SIG_FIFO_DATA:SIG_FIFO_TXE_N], SIG_FIFO_CLKOUT,
                         SIG_SLAVE0_OUT, SIG_SLAVE1_OUT, SIG_MST_CLK, SIG_MST_MOSI,
                         SIG_MST_SEL0_N, SIG_MST_SEL1_N, [SIG_PWM:SIG_LAST]});
   endfunction : pmux_can_out

   // signal may be taken from a pin
   function automatic logic pmux_can_in(input pmux_sel_t id);
      return (id inside {SIG_DEBUG, [SIG_SER_RXD:SIG_FIFO_DATA+7'h07],
                         [SIG_FIFO_RD_N:SIG_FIFO_OE_N], [SIG_SLAVE0_CLK:SIG_SLAVE1_MOSI],
                         SIG_SLAVE0_SEL_N, SIG_SLAVE1_SEL_N, SIG_MST_MISO,
                         [SIG_GPIO:SIG_LAST]});
   endfunction : pmux_can_in

   // level an input shows when no pin carries it; active low lines rest high
   function automatic logic pmux_idle(input pmux_sel_t id);
      return (id inside {[SIG_SER_RXD:SIG_SERIAL_RING_N], [SIG_FIFO_RD_N:SIG_FIFO_OE_N],
                         SIG_SLAVE0_SEL_N, SIG_SLAVE1_SEL_N});
   endfunction : pmux_idle

endpackage : pmux_pkg

// ===== design/pmux_top.sv
// Purpose: routes peripheral signals onto the configurable pins of the device
// Assumes: config and peripheral vectors on clk_i; pins asynchronous
// Notes: peripheral vectors are indexed by the signal identifiers of the package
//
// Contract
// - route selected peripheral signals to chosen pins
// - hard reset gives fixed default assignment
// - smallest package offers pins 0 to 11
// - middle package offers pins 0 to 27
// - largest package offers pins 0 to 43
// - hash-suffixed signals are active low
// - serial transmit-active output enables line driver
// - modem status inputs only, controls outputs only
// - space flag low when byte accepted
// - write strobe falling edge captures byte
// - data flag low while bytes buffered
// - read strobe low drives current byte
// - read strobe falling edge advances buffer
// - output enable, clock-out only in synchronous mode
// - master has two active-low slave selects
// - slaves take clock, select in; data out
// - signal only on pins matching its group
// - power-on reset leaves every pin input; the code loads the bidirectional default table after reset while enabled
// - each pad input, output or bidirectional
`timescale 1ns/10ps
`default_nettype none
module pmux_top
   import pmux_pkg::*;
#(
   parameter int PIN_COUNT = PMUX_PINS_LARGE, // 12, 28 or 44 by package option
   parameter int NSIG = PMUX_NSIG // number of signal identifiers
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic mux_en_i,
   input wire logic cfg_load_i,
   input wire logic [PIN_COUNT-1:0][PMUX_SEL_W-1:0] cfg_sel_i,
   input wire logic [PIN_COUNT-1:0][1:0] cfg_mode_i,
   input wire logic sync_fifo_i,
   input wire logic [PIN_COUNT-1:0] configurable_pin_in_i,
   output logic [PIN_COUNT-1:0] configurable_pin_out_o,
   output logic [PIN_COUNT-1:0] configurable_pin_oe_o,
   input wire logic [NSIG-1:0] per_out_i,
   input wire logic [NSIG-1:0] per_oe_i,
   output logic [NSIG-1:0] per_in_o,
   input wire logic fifo_tx_ready_i,
   output logic fifo_tx_push_o,
   output logic [7:0] fifo_tx_byte_o,
   input wire logic fifo_rx_valid_i,
   input wire logic [7:0] fifo_rx_byte_i,
   output logic fifo_rx_pop_o,
   output logic cfg_err_o,
   output logic [1:0] mux_state_o
);

   // ==============================
   // package option check
   // ==============================
   // any other pin count stops elaboration
   if (PIN_COUNT != PMUX_PINS_SMALL && PIN_COUNT != PMUX_PINS_MID
       && PIN_COUNT != PMUX_PINS_LARGE) begin : g_bad_count
      $error("pin count is not a package option");
   end

   // ==============================
   // functions
   // ==============================
   // default after hard reset: debugger on pin 0, gpio of the same group elsewhere
   function automatic pmux_sel_t default_sel(input int p);
      int g;
      g = (p < 40) ? p : p - 40;
      if (p == 0) begin
         return SIG_DEBUG;
      end
      return SIG_GPIO + pmux_sel_t'(g);
   endfunction : default_sel

   // a pin entry is legal when signal, group and direction agree
   function automatic logic entry_ok(input pmux_sel_t id, input logic [1:0] mode,
                                     input int p);
      logic grp_ok;
      logic dir_ok;
      grp_ok = (pmux_group(id) == 2'(p % PMUX_GROUPS));
      dir_ok = 1'b0;
      unique case (mode)
         2'(PAD_IN): dir_ok = pmux_can_in(id);
         2'(PAD_OUT): dir_ok = pmux_can_out(id);
         2'(PAD_BIDIR): dir_ok = pmux_can_in(id) & pmux_can_out(id);
         default: dir_ok = 1'b0;
      endcase
      return (id != SIG_NONE) && (id <= SIG_LAST) && grp_ok && dir_ok;
   endfunction : entry_ok

   // ==============================
   // state and configuration registers
   // ==============================
   pmux_state_e state_q; // controller state
   pmux_state_e state_d;
   pmux_sel_t [PIN_COUNT-1:0] sel_q; // signal per pin
   pmux_sel_t [PIN_COUNT-1:0] sel_d;
   logic [PIN_COUNT-1:0][1:0] mode_q; // pad mode per pin
   logic [PIN_COUNT-1:0][1:0] mode_d;
   logic err_q; // last load had a rejected entry
   logic err_d;
   logic [PIN_COUNT-1:0] reject; // per pin rejection of the presented table

   // next state: leaving enable returns every pad to input
   always_comb begin
      state_d = state_q;
      if (!mux_en_i) begin
         state_d = MUX_OFF;
      end else if (cfg_load_i) begin
         state_d = MUX_USER;
      end else if (state_q == MUX_OFF) begin
         state_d = MUX_DEFAULT;
      end
   end

   // rejection of each presented entry; an unused pin is no error
   always_comb begin
      reject = '0;
      for (int p = 0; p < PIN_COUNT; p++) begin
         reject[p] = (cfg_sel_i[p] != SIG_NONE) && !entry_ok(cfg_sel_i[p], cfg_mode_i[p], p);
      end
   end

   // table to hold; a rejected entry falls back to a plain input pad
   always_comb begin
      sel_d = sel_q;
      mode_d = mode_q;
      err_d = err_q;
      for (int p = 0; p < PIN_COUNT; p++) begin
         if (state_d == MUX_OFF) begin
            sel_d[p] = SIG_NONE;
            mode_d[p] = 2'(PAD_IN);
         end else if (state_d == MUX_USER && cfg_load_i) begin
            sel_d[p] = reject[p] ? SIG_NONE : cfg_sel_i[p];
            mode_d[p] = reject[p] ? 2'(PAD_IN) : cfg_mode_i[p];
         end else if (state_d == MUX_DEFAULT && state_q == MUX_OFF) begin
            sel_d[p] = default_sel(p);
            mode_d[p] = 2'(PAD_BIDIR);
         end
      end
      if (state_d == MUX_USER && cfg_load_i) begin
         err_d = |reject;
      end else if (state_d != MUX_USER) begin
         err_d = 1'b0;
      end
   end

   // configuration holds until the next load or disable
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= MUX_OFF;
         sel_q <= '0;
         mode_q <= '0;
         err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sel_q <= sel_d;
         mode_q <= mode_d;
         err_q <= err_d;
      end
   end

   // ==============================
   // pin input synchroniser
   // ==============================
   logic [PIN_COUNT-1:0] pin_meta_q; // first stage, read only by the second
   logic [PIN_COUNT-1:0] pin_sync_q; // safe pin levels

   // pins change at any time, so two stages before any routing logic
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= configurable_pin_in_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ==============================
   // parallel port handshake
   // ==============================
   pmux_fifo_if fif ();
   logic [NSIG-1:0] in_q; // routed peripheral inputs
   logic [NSIG-1:0] in_d;

   assign fif.wr_n = in_q[SIG_FIFO_WR_N];
   assign fif.rd_n = in_q[SIG_FIFO_RD_N];
   assign fif.oe_n = in_q[SIG_FIFO_OE_N];
   assign fif.sync_mode = sync_fifo_i;
   assign fif.bus_in = in_q[SIG_FIFO_DATA +: 8];

   pmux_fifo_port u_fifo_port (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .fif(fif),
      .tx_ready_i(fifo_tx_ready_i),
      .rx_valid_i(fifo_rx_valid_i),
      .rx_byte_i(fifo_rx_byte_i),
      .tx_push_o(fifo_tx_push_o),
      .tx_byte_o(fifo_tx_byte_o),
      .rx_pop_o(fifo_rx_pop_o)
   );

   // ==============================
   // output side: signal values and drive requests
   // ==============================
   logic [NSIG-1:0] sig_val; // level offered per signal
   logic [NSIG-1:0] sig_req; // bidirectional drive request per signal
   logic [NSIG-1:0] sig_allow; // signal may drive in the present port mode

   // parallel port members come from the handshake logic, not from the vectors;
   // the transmit-active level is passed as the serial logic presents it
   always_comb begin
      sig_val = per_out_i;
      sig_req = per_oe_i;
      sig_allow = '1;
      sig_val[SIG_FIFO_DATA +: 8] = fif.bus_out;
      sig_req[SIG_FIFO_DATA +: 8] = {8{fif.bus_oe}};
      sig_val[SIG_FIFO_TXE_N] = fif.txe_n;
      sig_val[SIG_FIFO_RXF_N] = fif.rxf_n;
      sig_allow[SIG_FIFO_CLKOUT] = sync_fifo_i;
   end

   // ==============================
   // pin drive
   // ==============================
   logic [PIN_COUNT-1:0] pin_out_d;
   logic [PIN_COUNT-1:0] pin_oe_d;
   logic [PIN_COUNT-1:0] pin_out_q;
   logic [PIN_COUNT-1:0] pin_oe_q;

   // each pin names one signal, so no pin ever has two drivers
   always_comb begin
      for (int p = 0; p < PIN_COUNT; p++) begin
         pin_out_d[p] = sig_val[sel_q[p]];
         unique case (mode_q[p])
            2'(PAD_OUT): pin_oe_d[p] = sig_allow[sel_q[p]];
            2'(PAD_BIDIR): pin_oe_d[p] = sig_allow[sel_q[p]] & sig_req[sel_q[p]];
            default: pin_oe_d[p] = 1'b0;
         endcase
         if (sel_q[p] == SIG_NONE) begin
            pin_oe_d[p] = 1'b0;
         end
      end
   end

   // ==============================
   // input side routing
   // ==============================
   // lowest pin wins when two pins carry the same input; the loop runs downward
   always_comb begin
      for (int s = 0; s < NSIG; s++) begin
         in_d[s] = pmux_idle(pmux_sel_t'(s));
         for (int p = PIN_COUNT - 1; p >= 0; p--) begin
            if (sel_q[p] == pmux_sel_t'(s) && mode_q[p] != 2'(PAD_OUT)) begin
               in_d[s] = pin_sync_q[p];
            end
         end
      end
      if (!sync_fifo_i) begin
         in_d[SIG_FIFO_OE_N] = 1'b1;
      end
   end

   // routed levels and pad controls leave from flip-flops
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         in_q <= '0;
         pin_out_q <= '0;
         pin_oe_q <= '0;
      end else begin
         in_q <= in_d;
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   assign configurable_pin_out_o = pin_out_q;
   assign configurable_pin_oe_o = pin_oe_q;
   assign per_in_o = in_q;
   assign cfg_err_o = err_q;
   assign mux_state_o = state_q;

endmodule : pmux_top
`default_nettype wire
